// ---- logic/relay_trip_logic.v ----
// Per-relay trip logic with an AHB-Lite register slave
//
// Overview of operation
// - Code 0 disables relay, output off
// - Code 1 trips at ON, resets at OFF
// - Code 2 in-bounds, code 3 out-of-bounds
// - In-bounds: active while level inside range
// - Out-of-bounds: active when level leaves range
// - Code 4 compares rate of change instead
// - Temperature mode compares temperature against setpoints
// - Code 6 echo loss, code 7 cable fault
// - Flow pulse per scaled quantity or interval
// - Code 50 fixed setpoints, multiple pumps run
// - Code 51 fixed setpoints, single pump runs
// - Code 52 rotating setpoints, multiple pumps run
// - Alternate backup rotates setpoints, single pump
// - Codes 54/55 service ratio, assist/backup; the logic rotates them exactly as codes 52/53
// - Code 56 starts alternate, stops first-started first
// - Code 64 drives flush device by flush settings
// - Code 65 relay follows external commands
// - Setpoints referenced from the empty point
// - Reaching ON setpoint leaves normal state
// - Reaching OFF setpoint returns normal state
// - Bounds modes: ON is upper limit
// - Bounds modes: OFF is lower limit
// - Setpoints in span level units, except codes 4/5 (rate, temperature)
`timescale 1ns/1ps
`include "relay_trip_defines.vh"

module relay_trip_logic #(
    parameter NUM_RELAYS = 6,
    parameter IDX_W      = 3
) (
    // Clock and reset
    input  wire                  hclk,
    input  wire                  hresetn,
    // AHB-Lite slave
    input  wire                  hsel,
    input  wire [31:0]           haddr,
    input  wire [1:0]            htrans,
    input  wire                  hwrite,
    input  wire [2:0]            hsize,
    input  wire [31:0]           hwdata,
    input  wire                  hready,
    output reg                   hreadyout,
    output reg  [31:0]           hrdata,
    output reg                   hresp,
    // Process values from measurement logic
    input  wire [15:0]           distance,
    input  wire signed [15:0]    rate,
    input  wire signed [15:0]    temperature,
    input  wire                  echo_loss,
    input  wire                  cable_fault,
    input  wire                  totalizer_pulse,
    input  wire                  tick,
    // Relay drives
    output reg  [NUM_RELAYS-1:0] relay_out
);

    // Configuration storage
    reg         [7:0]            relay_control_function [0:NUM_RELAYS-1];
    reg  signed [15:0]           relay_on_setpoint      [0:NUM_RELAYS-1];
    reg  signed [15:0]           relay_off_setpoint     [0:NUM_RELAYS-1];
    reg         [31:0]           relay_aux              [0:NUM_RELAYS-1];
    reg         [NUM_RELAYS-1:0] comm_cmd;
    reg         [15:0]           empty_reference;
    reg         [23:0]           flush_system_settings;

    // Control state
    reg         [NUM_RELAYS-1:0] demand;
    reg         [NUM_RELAYS-1:0] pulse_hold;
    reg         [15:0]           qty_cnt  [0:NUM_RELAYS-1];
    reg         [15:0]           ival_cnt [0:NUM_RELAYS-1];
    reg         [IDX_W-1:0]      rot;
    reg                          alt_busy;
    reg         [7:0]            flush_cnt;
    reg         [15:0]           flush_timer;

    // Bus state
    reg                          wr_pend;
    reg                          rd_pend;
    reg         [11:0]           acc_addr;

    // Combinational results
    reg         [NUM_RELAYS-1:0] next_demand;
    reg         [NUM_RELAYS-1:0] next_relay;
    reg         [NUM_RELAYS-1:0] pump_mask;
    reg         [NUM_RELAYS-1:0] alt_mask;
    reg         [NUM_RELAYS-1:0] qty_hit;
    reg         [NUM_RELAYS-1:0] ival_hit;
    reg                          top_found;
    reg         [IDX_W-1:0]      top_slot;
    reg         [IDX_W-1:0]      top_idx;
    reg         [31:0]           rd_data;

    wire signed [15:0]           level;
    wire                         take;
    wire                         flush_active;
    wire                         pump_start;
    wire                         any_alt;
    wire        [IDX_W-1:0]      acc_idx;
    wire        [2:0]            acc_fld;
    wire                         acc_relay;

    integer i, j, k, m;
    integer s, grp_s;
    reg         [7:0]            fn, grp_fn;
    reg  signed [15:0]           val;
    reg  signed [15:0]           on_v;
    reg  signed [15:0]           off_v;
    reg                          inb;
    reg                          hit_on;
    reg                          hit_off;

    // Level measured up from empty, in span units
    assign level = $signed(empty_reference - distance);

    assign take      = hsel & hready & htrans[1];
    assign acc_idx   = acc_addr[IDX_W+4:5];
    assign acc_fld   = acc_addr[4:2];
    assign acc_relay = (acc_addr[11:8] == `REGION_RELAY) &&
                       (acc_addr[7:5] < NUM_RELAYS);

    assign flush_active = (flush_timer != 16'h0000);
    assign pump_start   = |(next_relay & ~relay_out & pump_mask);
    assign any_alt      = |(demand & alt_mask);

    // Group membership and backup selection
    always @*
    begin
        pump_mask = {NUM_RELAYS{1'b0}};
        alt_mask  = {NUM_RELAYS{1'b0}};
        top_found = 1'b0;
        top_slot  = {IDX_W{1'b0}};
        top_idx   = {IDX_W{1'b0}};
        grp_fn    = `FN_OFF;
        grp_s     = 0;
        for (j = 0; j < NUM_RELAYS; j = j + 1)
        begin
            grp_fn = relay_control_function[j];
            grp_s  = j + rot;
            if (grp_s >= NUM_RELAYS)
                grp_s = grp_s - NUM_RELAYS;
            pump_mask[j] = (grp_fn >= `FN_FDA) && (grp_fn <= `FN_FIFO);
            alt_mask[j]  = (grp_fn >= `FN_ADA) && (grp_fn <= `FN_FIFO);
            if (((grp_fn == `FN_FDB) || (grp_fn == `FN_ADB) || (grp_fn == `FN_SRB)) &&
                demand[j] && (!top_found || (grp_s[IDX_W-1:0] >= top_slot)))
            begin
                top_found = 1'b1;
                top_slot  = grp_s[IDX_W-1:0];
                top_idx   = j[IDX_W-1:0];
            end
        end
    end

    // Per-relay algorithm
    always @*
    begin
        next_demand = demand;
        next_relay  = {NUM_RELAYS{1'b0}};
        qty_hit     = {NUM_RELAYS{1'b0}};
        ival_hit    = {NUM_RELAYS{1'b0}};
        fn          = `FN_OFF;
        val         = level;
        on_v        = `RST_SP;
        off_v       = `RST_SP;
        inb         = 1'b0;
        hit_on      = 1'b0;
        hit_off     = 1'b0;
        for (i = 0; i < NUM_RELAYS; i = i + 1)
        begin
            fn = relay_control_function[i];
            s  = i + rot;
            if (s >= NUM_RELAYS)
                s = s - NUM_RELAYS;
            if ((fn >= `FN_ADA) && (fn <= `FN_FIFO))
            begin
                on_v  = relay_on_setpoint[s];
                off_v = relay_off_setpoint[s];
                if (fn == `FN_FIFO)
                    off_v = relay_off_setpoint[NUM_RELAYS-1-s];
            end
            else
            begin
                on_v  = relay_on_setpoint[i];
                off_v = relay_off_setpoint[i];
            end
            case (fn)
                `FN_RATE: val = rate;
                `FN_TEMP: val = temperature;
                default:  val = level;
            endcase
            if (on_v >= off_v)
            begin
                hit_on  = (val >= on_v);
                hit_off = (val <= off_v);
            end
            else
            begin
                hit_on  = (val <= on_v);
                hit_off = (val >= off_v);
            end
            if (hit_on)
                next_demand[i] = 1'b1;
            else if (hit_off)
                next_demand[i] = 1'b0;
            else
                next_demand[i] = demand[i];
            inb = (level <= relay_on_setpoint[i]) &&
                  (level >= relay_off_setpoint[i]);
            qty_hit[i]  = totalizer_pulse &&
                          (qty_cnt[i] + 16'h0001 >= relay_aux[i][15:0]);
            ival_hit[i] = tick && (relay_aux[i][31:16] != 16'h0000) &&
                          (ival_cnt[i] + 16'h0001 >= relay_aux[i][31:16]);
            case (fn)
                `FN_OFF:      next_relay[i] = 1'b0;
                `FN_LEVEL:    next_relay[i] = next_demand[i];
                `FN_INB:      next_relay[i] = inb;
                `FN_OUTB:     next_relay[i] = !inb;
                `FN_RATE:     next_relay[i] = next_demand[i];
                `FN_TEMP:     next_relay[i] = next_demand[i];
                `FN_ECHO:     next_relay[i] = echo_loss;
                `FN_CABLE:    next_relay[i] = cable_fault;
                `FN_FLOW_QTY: next_relay[i] = pulse_hold[i];
                `FN_FLOW_INT: next_relay[i] = pulse_hold[i];
                `FN_FDA:      next_relay[i] = next_demand[i];
                `FN_ADA:      next_relay[i] = next_demand[i];
                `FN_SRA:      next_relay[i] = next_demand[i];
                `FN_FIFO:     next_relay[i] = next_demand[i];
                `FN_FDB,
                `FN_ADB,
                `FN_SRB:      next_relay[i] = demand[i] && top_found &&
                                              (top_idx == i[IDX_W-1:0]);
                `FN_FLUSH:    next_relay[i] = flush_active;
                `FN_COMM:     next_relay[i] = comm_cmd[i];
                default:      next_relay[i] = 1'b0;
            endcase
        end
    end

    // Relay state, counters, rotation and flush timing
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            relay_out   <= {NUM_RELAYS{1'b0}};
            demand      <= {NUM_RELAYS{1'b0}};
            pulse_hold  <= {NUM_RELAYS{1'b0}};
            rot         <= {IDX_W{1'b0}};
            alt_busy    <= 1'b0;
            flush_cnt   <= 8'h00;
            flush_timer <= 16'h0000;
            for (k = 0; k < NUM_RELAYS; k = k + 1)
            begin
                qty_cnt[k]  <= 16'h0000;
                ival_cnt[k] <= 16'h0000;
            end
        end
        else
        begin
            relay_out <= next_relay;
            demand    <= next_demand;
            for (k = 0; k < NUM_RELAYS; k = k + 1)
            begin
                if ((relay_control_function[k] == `FN_FLOW_QTY) ||
                    (relay_control_function[k] == `FN_FLOW_INT))
                begin
                    if (qty_hit[k])
                        qty_cnt[k] <= 16'h0000;
                    else if (totalizer_pulse)
                        qty_cnt[k] <= qty_cnt[k] + 16'h0001;
                    if (ival_hit[k] ||
                        (relay_control_function[k] != `FN_FLOW_INT))
                        ival_cnt[k] <= 16'h0000;
                    else if (tick)
                        ival_cnt[k] <= ival_cnt[k] + 16'h0001;
                    // Pulse stands until the next tick
                    if (qty_hit[k] || ival_hit[k])
                        pulse_hold[k] <= 1'b1;
                    else if (tick)
                        pulse_hold[k] <= 1'b0;
                end
                else
                begin
                    qty_cnt[k]    <= 16'h0000;
                    ival_cnt[k]   <= 16'h0000;
                    pulse_hold[k] <= 1'b0;
                end
            end
            // Advance lead pump once the group has fully stopped
            alt_busy <= any_alt;
            if (alt_busy && !any_alt)
            begin
                if (rot == NUM_RELAYS - 1)
                    rot <= {IDX_W{1'b0}};
                else
                    rot <= rot + 1'b1;
            end
            // Flush after a set number of cycles in which a pump starts
            if (flush_active && tick)
                flush_timer <= flush_timer - 16'h0001;
            if (pump_start && (flush_system_settings[7:0] != 8'h00))
            begin
                if (flush_cnt + 8'h01 >= flush_system_settings[7:0])
                begin
                    flush_cnt   <= 8'h00;
                    flush_timer <= flush_system_settings[23:8];
                end
                else
                    flush_cnt <= flush_cnt + 8'h01;
            end
        end
    end

    // Read data select
    always @*
    begin
        rd_data = 32'h0000_0000;
        if (acc_relay)
        begin
            case (acc_fld)
                `FLD_FUNC: rd_data = {24'h00_0000, relay_control_function[acc_idx]};
                `FLD_ON:   rd_data = {16'h0000, relay_on_setpoint[acc_idx]};
                `FLD_OFF:  rd_data = {16'h0000, relay_off_setpoint[acc_idx]};
                `FLD_AUX:  rd_data = relay_aux[acc_idx];
                `FLD_CMD:  rd_data = {31'h0000_0000, comm_cmd[acc_idx]};
                default:   rd_data = 32'h0000_0000;
            endcase
        end
        else
        begin
            case (acc_addr)
                `REG_STATUS: rd_data = {13'h0000, rot, 2'b00, demand,
                                        2'b00, relay_out};
                `REG_EMPTY:  rd_data = {16'h0000, empty_reference};
                `REG_FLUSH:  rd_data = {8'h00, flush_system_settings};
                default:     rd_data = 32'h0000_0000;
            endcase
        end
    end

    // AHB-Lite slave: writes zero wait, reads one wait state
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout             <= 1'b1;
            hrdata                <= 32'h0000_0000;
            hresp                 <= 1'b0;
            wr_pend               <= 1'b0;
            rd_pend               <= 1'b0;
            acc_addr              <= 12'h000;
            comm_cmd              <= {NUM_RELAYS{1'b0}};
            empty_reference       <= `RST_EMPTY;
            flush_system_settings <= `RST_FLUSH;
            for (m = 0; m < NUM_RELAYS; m = m + 1)
            begin
                relay_control_function[m] <= `RST_FUNC;
                relay_on_setpoint[m]      <= `RST_SP;
                relay_off_setpoint[m]     <= `RST_SP;
                relay_aux[m]              <= `RST_AUX;
            end
        end
        else
        begin
            hresp   <= 1'b0;
            wr_pend <= 1'b0;
            if (rd_pend)
            begin
                hrdata    <= rd_data;
                hreadyout <= 1'b1;
                rd_pend   <= 1'b0;
            end
            if (wr_pend && acc_relay)
            begin
                case (acc_fld)
                    `FLD_FUNC: relay_control_function[acc_idx] <= hwdata[7:0];
                    `FLD_ON:   relay_on_setpoint[acc_idx]      <= hwdata[15:0];
                    `FLD_OFF:  relay_off_setpoint[acc_idx]     <= hwdata[15:0];
                    `FLD_AUX:  relay_aux[acc_idx]              <= hwdata;
                    `FLD_CMD:  comm_cmd[acc_idx]               <= hwdata[0];
                    default:   comm_cmd                        <= comm_cmd;
                endcase
            end
            else if (wr_pend && (acc_addr == `REG_EMPTY))
                empty_reference <= hwdata[15:0];
            else if (wr_pend && (acc_addr == `REG_FLUSH))
                flush_system_settings <= hwdata[23:0];
            if (take)
            begin
                acc_addr <= haddr[11:0];
                if (hwrite)
                    wr_pend <= (hsize == `WORD_SIZE);
                else
                begin
                    rd_pend   <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end

endmodule // relay_trip_logic

// ---- logic/relay_trip_defines.vh ----
// Constants for the relay trip logic: function codes and register map
`ifndef RELAY_TRIP_DEFINES_VH
`define RELAY_TRIP_DEFINES_VH

// Control function codes
`define FN_OFF       8'h00
`define FN_LEVEL     8'h01
`define FN_INB       8'h02
`define FN_OUTB      8'h03
`define FN_RATE      8'h04
`define FN_TEMP      8'h05
`define FN_ECHO      8'h06
`define FN_CABLE     8'h07
`define FN_FLOW_QTY  8'h08
`define FN_FLOW_INT  8'h09
`define FN_FDA       8'h32
`define FN_FDB       8'h33
`define FN_ADA       8'h34
`define FN_ADB       8'h35
`define FN_SRA       8'h36
`define FN_SRB       8'h37
`define FN_FIFO      8'h38
`define FN_FLUSH     8'h40
`define FN_COMM      8'h41

// Per-relay word within a relay block
`define FLD_FUNC     3'h0
`define FLD_ON       3'h1
`define FLD_OFF      3'h2
`define FLD_AUX      3'h3
`define FLD_CMD      3'h4

// Region select in haddr[11:8]
`define REGION_RELAY 4'h0
`define REGION_GLOB  4'h1

// Global registers, byte offsets
`define REG_STATUS   12'h100
`define REG_EMPTY    12'h104
`define REG_FLUSH    12'h108

// Reset values and the hsize code of a word transfer
`define RST_FUNC     8'h00
`define RST_SP       16'h0000
`define RST_AUX      32'h0000_0000
`define RST_EMPTY    16'h0000
`define RST_FLUSH    24'h00_0000
`define WORD_SIZE    3'h2
`endif

// ---- verification/relay_trip_logic_chk.sv ----
// Assertion checker for the relay trip logic, bound to its top module
`timescale 1ns/1ps
`include "relay_trip_defines.vh"
module relay_trip_logic_chk #(
    parameter NUM_RELAYS = 6,
    parameter IDX_W      = 3
) (
    // Clock and reset
    input logic                  hclk,
    input logic                  hresetn,
    // Register bus
    input logic                  hsel,
    input logic [31:0]           haddr,
    input logic [1:0]            htrans,
    input logic                  hwrite,
    input logic [2:0]            hsize,
    input logic [31:0]           hwdata,
    input logic                  hready,
    input logic                  hreadyout,
    input logic [31:0]           hrdata,
    input logic                  hresp,
    // Process values
    input logic [15:0]           distance,
    input logic signed [15:0]    rate,
    input logic signed [15:0]    temperature,
    input logic                  echo_loss,
    input logic                  cable_fault,
    input logic                  totalizer_pulse,
    input logic                  tick,
    // Relay drives
    input logic [NUM_RELAYS-1:0] relay_out
);
    // Shadow of relay 0 settings and the empty reference
    logic               wr_q;
    logic [11:0]        wa_q;
    logic [7:0]         fn0;
    logic signed [15:0] on0, off0;
    logic [15:0]        emp;
    logic               cmd0;
    wire signed [15:0]  lvl = emp - distance;
    wire                in_rng = (lvl >= off0) && (lvl <= on0);

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            wa_q <= 12'h000;
            fn0  <= 8'h00;
            on0  <= 16'h0000;
            off0 <= 16'h0000;
            emp  <= 16'h0000;
            cmd0 <= 1'b0;
        end
        else if (hready)
        begin
            wr_q <= hsel && htrans[1] && hwrite && (hsize == `WORD_SIZE);
            wa_q <= haddr[11:0];
            if (wr_q)
                case (wa_q)
                    12'h000: fn0  <= hwdata[7:0];
                    12'h004: on0  <= hwdata[15:0];
                    12'h008: off0 <= hwdata[15:0];
                    12'h010: cmd0 <= hwdata[0];
                    12'h104: emp  <= hwdata[15:0];
                    default: ;
                endcase
        end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    off_keeps_idle_a: assert property (fn0 == `FN_OFF |=> !relay_out[0])
        else $error("disabled relay active");
    level_trips_a: assert property (fn0 == `FN_LEVEL && on0 >= off0
        && lvl >= on0 |=> relay_out[0])
        else $error("level at ON did not trip");
    level_resets_a: assert property (fn0 == `FN_LEVEL && on0 >= off0
        && lvl <= off0 && lvl < on0 |=> !relay_out[0])
        else $error("level at OFF did not reset");
    level_holds_a: assert property (fn0 == `FN_LEVEL && $past(fn0) == `FN_LEVEL
        && lvl > off0 && lvl < on0 |=> $stable(relay_out[0]))
        else $error("relay changed between setpoints");
    inside_band_a: assert property (fn0 == `FN_INB |=> relay_out[0] == $past(in_rng))
        else $error("in-bounds output wrong");
    outside_band_a: assert property (fn0 == `FN_OUTB |=> relay_out[0] != $past(in_rng))
        else $error("out-of-bounds output wrong");
    rate_trips_a: assert property (fn0 == `FN_RATE && on0 >= off0
        && rate >= on0 |=> relay_out[0])
        else $error("rate at ON did not trip");
    temp_trips_a: assert property (fn0 == `FN_TEMP && on0 >= off0
        && temperature >= on0 |=> relay_out[0])
        else $error("temperature at ON did not trip");
    echo_follow_a: assert property (fn0 == `FN_ECHO |=> relay_out[0] == $past(echo_loss))
        else $error("echo loss not followed");
    cable_follow_a: assert property (fn0 == `FN_CABLE |=> relay_out[0] == $past(cable_fault))
        else $error("cable fault not followed");
    command_follow_a: assert property (fn0 == `FN_COMM |=> relay_out[0] == $past(cmd0))
        else $error("external command not followed");
endmodule // relay_trip_logic_chk

bind relay_trip_logic relay_trip_logic_chk #(.NUM_RELAYS(NUM_RELAYS), .IDX_W(IDX_W)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .distance(distance),
    .rate(rate), .temperature(temperature), .echo_loss(echo_loss),
    .cable_fault(cable_fault), .totalizer_pulse(totalizer_pulse), .tick(tick),
    .relay_out(relay_out)
);

// ---- verification/pump_bank_model.sv ----
// Pumps and alarms on the relay contacts: counts starts and running units
`timescale 1ns/1ps
module pump_bank_model #(
    parameter N = 6
) (
    // Clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    // Relay contacts
    input  wire [N-1:0] relay_out,
    // Observations
    output int          starts,
    output int          running
);
    logic [N-1:0] prev;

    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            prev   <= '0;
            starts <= 0;
        end
        else
        begin
            prev   <= relay_out;
            starts <= starts + $countones(relay_out & ~prev);
        end

    assign running = $countones(relay_out);
endmodule // pump_bank_model

// ---- verification/relay_trip_logic_tb_top.sv ----
// Self-checking testbench for the relay trip logic
`timescale 1ns/1ps
`include "relay_trip_defines.vh"
module relay_trip_logic_tb_top;
    localparam int ON  = 600;
    localparam int OFF = 200;
    localparam int EMP = 1000;
    logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]        haddr, hwdata, hrdata, rd;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic [15:0]        distance;
    logic signed [15:0] rate, temperature;
    logic               echo_loss, cable_fault, totalizer_pulse, tick;
    logic [5:0]         relay_out;
    int                 failures = 0;
    int                 tests_run = 0;
    int                 starts, running, i, s0;
    int                 codes[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 50, 51, 52, 53, 54, 55, 56, 64, 65};

    relay_trip_logic u_relay_trip_logic (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .distance(distance),
        .rate(rate), .temperature(temperature), .echo_loss(echo_loss),
        .cable_fault(cable_fault), .totalizer_pulse(totalizer_pulse), .tick(tick),
        .relay_out(relay_out)
    );
    pump_bank_model u_pump_bank_model (
        .hclk(hclk), .hresetn(hresetn), .relay_out(relay_out),
        .starts(starts), .running(running)
    );

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic end_of_test;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for hready high at a falling edge, takes read data there
    task automatic wait_rdy;
        logic ok;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge hclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end
    endtask

    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0000_0000;
        wait_rdy;
    endtask

    // Relay 0 and running count one edge after the inputs land
    task automatic look(input int e, input int r);
        @(posedge hclk);
        @(negedge hclk);
        if (e >= 0)
            chk({31'h0, relay_out[0]}, e);
        chk(running, r);
        @(posedge hclk);
    endtask

    // Reference model for relay 0 over random process values
    task automatic run_mode(input int code, input int n);
        int v, w, e, p, k;
        p = 0;
        ahb(1, 12'h000, code);
        for (k = 0; k < n; k++)
        begin
            w = $urandom_range(1000) - 100;
            v = (k == 0) ? ON : (k == 1) ? OFF : (k == 2) ? ON : $urandom_range(1000) - 100;
            distance <= 16'(EMP - ((code < 4) ? v : w));
            rate <= 16'((code == 4) ? v : w);
            temperature <= 16'((code == 5) ? v : w);
            echo_loss <= v[0];
            cable_fault <= v[1];
            if (code == 2 || code == 3)
                e = ((v >= OFF) && (v <= ON)) ^ (code == 3);
            else if (code == 6 || code == 7)
                e = v[code - 6];
            else
                e = (v >= ON) ? 1 : (v <= OFF) ? 0 : p;
            p = e;
            look(e, e);
        end
    endtask

    initial
    begin
        #40000;
        failures++;
        end_of_test;
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        distance = 16'h0000;
        rate = 16'h0000;
        temperature = 16'h0000;
        {echo_loss, cable_fault, totalizer_pulse, tick} = 4'h0;
        void'($urandom(31));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        look(0, 0);
        for (i = 0; i < 6; i++)
        begin
            ahb(0, 12'(i * 32), 0);
            chk(rd, 0);
        end
        ahb(1, 12'h0FC, 32'hFFFF_FFFF);
        ahb(0, 12'h0FC, 0);
        chk(rd, 0);
        ahb(1, 12'h024, 32'hFFFF_FF9C);
        ahb(0, 12'h024, 0);
        chk(rd, 32'h0000_FF9C);
        foreach (codes[k])
        begin
            ahb(1, 12'h020, codes[k]);
            ahb(0, 12'h020, 0);
            chk(rd, codes[k]);
            chk({31'h0, hresp}, 0);
        end
        ahb(1, 12'h020, 0);
        ahb(1, 12'h104, EMP);
        ahb(1, 12'h004, ON);
        ahb(1, 12'h008, OFF);
        for (i = 1; i < 8; i++)
            run_mode(i, 24);
        ahb(1, 12'h000, `FN_OFF);
        echo_loss <= 1'b1;
        distance <= 16'(EMP - 900);
        look(0, 0);
        ahb(1, 12'h000, `FN_COMM);
        ahb(1, 12'h010, 32'h0000_0001);
        look(1, 1);
        ahb(1, 12'h010, 32'h0000_0000);
        look(0, 0);
        ahb(1, 12'h00C, 32'h0000_0003);
        ahb(1, 12'h000, `FN_FLOW_QTY);
        for (i = 1; i <= 3; i++)
        begin
            totalizer_pulse <= 1'b1;
            @(posedge hclk);
            totalizer_pulse <= 1'b0;
            look(i == 3, i == 3);
        end
        tick <= 1'b1;
        @(posedge hclk);
        tick <= 1'b0;
        look(0, 0);
        distance <= 16'(EMP - 700);
        s0 = starts;
        for (i = 0; i < 3; i++)
        begin
            ahb(1, 12'(i * 32 + 4), ON);
            ahb(1, 12'(i * 32 + 8), OFF);
        end
        for (i = 2; i >= 0; i--)
            ahb(1, 12'(i * 32), `FN_FDB);
        look(-1, 1);
        @(negedge hclk);
        chk(starts - s0, 1);
        @(posedge hclk);
        for (i = 0; i < 3; i++)
            ahb(1, 12'(i * 32), `FN_FDA);
        look(1, 3);
        distance <= 16'(EMP - 100);
        look(0, 0);
        ahb(1, 12'h108, 32'h0000_0201);
        ahb(1, 12'h060, `FN_FLUSH);
        distance <= 16'(EMP - 700);
        look(-1, 3);
        look(-1, 4);
        end_of_test;
    end
endmodule // relay_trip_logic_tb_top
